// File: src/can_extended_id_buffer_map.sv
// Functional notes
// R1: 29-bit id, bit 28 sent first; standard frames here send id bit 10 first
// R2: smaller identifier value wins arbitration
// R3: byte1 bits 7-5 id20-18, 2-0 id17-15
// R4: byte2 id14-7, byte3 bits 7-1 id6-0
// R5: software writes substitute remote bit as one
// R6: received substitute remote bit stored at byte1.4
// R7: byte1 bit 3 selects standard/extended format
// R8: byte3 bit 0 is remote request flag
// R9: byte0 holds id28-21, bit 28 at 7
// R10: tx buffer access only when empty, selected
// R11: rx buffer readable when full, never writable
// R12: identifier bytes have no reset value
`timescale 1ns/10ps
`default_nettype none

module can_extended_id_buffer_map (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_store,
  input wire can_idbuf_pkg::id_frame_t rx_frame,
  input wire logic bit_tick,
  input wire logic can_rx,
  output logic can_tx,
  output logic tx_done,
  output logic arb_lost
);
`include "can_idbuf_consts.svh"

  // ==========================================================
  // state
  logic [7:0] tx_mem [0:3];
  logic [7:0] rx_mem [0:3];
  logic [7:0] next_tx_mem [0:3];
  logic [7:0] next_rx_mem [0:3];
  logic tx_sel, next_tx_sel;
  logic tx_empty, next_tx_empty;
  logic rx_full, next_rx_full;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic rx_meta, rx_sync;
  logic [2:0] idx;
  logic wr_go, rd_go, tx_open, rx_open, ser_start, ser_busy;
  can_idbuf_pkg::id_bytes_t tx_bytes, rx_bytes;
  can_idbuf_pkg::id_frame_t tx_frame;

  function automatic logic is_id_byte(input logic [2:0] i);
    is_id_byte = (i <= `IDX_ID_BYTE3);
  endfunction

  assign idx = avs_address[4:2];
  // a write completes on the edge where waitrequest is low; read data is registered one edge earlier
  assign wr_go = avs_write && !avs_waitrequest;
  assign rd_go = avs_read && avs_waitrequest;
  assign tx_open = tx_sel && tx_empty; // R10
  assign rx_open = !tx_sel && rx_full; // R11
  // done pulse cycle: shifter idle but empty not yet set, so no reload
  assign ser_start = !tx_empty && !ser_busy && !tx_done;

  // ==========================================================
  // bus pin synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_meta <= `RECESSIVE;
      rx_sync <= `RECESSIVE;
    end else begin
      rx_meta <= can_rx;
      rx_sync <= rx_meta;
    end
  end

  // ==========================================================
  // byte codec and arbitration shifter
  generate
    for (genvar g = 0; g < 4; g++) begin : g_bytes
      assign tx_bytes[g] = tx_mem[g];
    end
  endgenerate

  id_byte_codec codec_tx (
    .bytes_in(tx_bytes),
    .frame_in(rx_frame),
    .bytes_out(rx_bytes),
    .frame_out(tx_frame)
  );

  id_arb_shifter shifter (
    .clk(clk),
    .rst_n(rst_n),
    .start(ser_start),
    .frame(tx_frame),
    .bit_tick(bit_tick),
    .bus_bit(rx_sync),
    .tx_bit(can_tx),
    .busy(ser_busy),
    .done(tx_done),
    .lost(arb_lost)
  );

  // ==========================================================
  // slave handshake: one wait cycle, then one cycle low
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
    end
    if (rd_go) begin
      next_readdata = 32'h0000_0000;
      if (is_id_byte(idx)) begin
        // locked buffer reads as zero rather than stale bytes
        if (tx_open) begin
          next_readdata = {24'h00_0000, tx_mem[idx[1:0]]}; // R10
        end else if (rx_open) begin
          next_readdata = {24'h00_0000, rx_mem[idx[1:0]]}; // R11
        end
      end else if (idx == `IDX_TX_SEL) begin
        next_readdata[`SEL_TX_BIT] = tx_sel;
      end else if (idx == `IDX_STATUS) begin
        next_readdata[`STAT_TXE_BIT] = tx_empty;
        next_readdata[`STAT_RXF_BIT] = rx_full;
      end else if (idx == `IDX_TX_CTRL) begin
        next_readdata[`CTRL_BUSY_BIT] = ser_busy;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // ==========================================================
  // control and flags
  always_comb begin
    next_tx_sel = tx_sel;
    next_tx_empty = tx_empty;
    next_rx_full = rx_full;
    if (wr_go && idx == `IDX_TX_SEL) begin
      next_tx_sel = avs_writedata[`SEL_TX_BIT];
    end
    if (wr_go && idx == `IDX_TX_CTRL && avs_writedata[`CTRL_REQ_BIT]) begin
      next_tx_empty = 1'b0;
    end
    if (tx_done) begin
      next_tx_empty = 1'b1;
    end
    if (wr_go && idx == `IDX_STATUS && avs_writedata[`STAT_RXF_BIT]) begin
      next_rx_full = 1'b0;
    end
    // a clear beats a new frame in the same cycle: full is still set, so the frame is dropped
    if (rx_store && !rx_full) begin
      next_rx_full = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_sel <= `SEL_RESET;
      tx_empty <= `TXE_RESET;
      rx_full <= `RXF_RESET;
    end else begin
      tx_sel <= next_tx_sel;
      tx_empty <= next_tx_empty;
      rx_full <= next_rx_full;
    end
  end

  // ==========================================================
  // identifier buffers, ram-like, no reset
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_tx_mem[i] = tx_mem[i];
      next_rx_mem[i] = rx_mem[i];
    end
    if (wr_go && is_id_byte(idx) && tx_open) begin
      // srr is kept as written; software must set it
      next_tx_mem[idx[1:0]] = avs_writedata[7:0]; // R10 R5
    end
    // full buffer is not overwritten: the new frame is dropped
    if (rx_store && !rx_full) begin
      for (int i = 0; i < 4; i++) begin
        next_rx_mem[i] = rx_bytes[i]; // R6 R7 R8
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      tx_mem[i] <= next_tx_mem[i]; // R12
      rx_mem[i] <= next_rx_mem[i];
    end
  end

  // ==========================================================
  // checks
  a_wait_one: assert property (@(posedge clk) disable iff (!rst_n)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_ack_single: assert property (@(posedge clk) disable iff (!rst_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_rx_srr: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_store && !rx_full) |=> (rx_mem[1][4] == $past(rx_frame.srr)))
    else $error("received srr not stored at byte1 bit 4"); // R6
  a_rx_ide: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_store && !rx_full) |=> (rx_mem[1][3] == $past(rx_frame.ide)))
    else $error("received format flag not at byte1 bit 3"); // R7
  a_rx_rtr: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_store && !rx_full) |=> (rx_mem[3][0] == $past(rx_frame.rtr)))
    else $error("received rtr not at byte3 bit 0"); // R8
  a_rx_high_id: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_store && !rx_full) |=>
      (rx_mem[0] == $past(rx_frame.id[28:21])) &&
      (rx_mem[1][7:5] == $past(rx_frame.id[20:18])))
    else $error("id bits 28-18 misplaced"); // R9 R3
  a_rx_low_id: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_store && !rx_full) |=>
      (rx_mem[2] == $past(rx_frame.id[14:7])) &&
      (rx_mem[3][7:1] == $past(rx_frame.id[6:0])) &&
      (rx_mem[1][2:0] == $past(rx_frame.id[17:15])))
    else $error("id bits 17-0 misplaced"); // R3 R4
  a_tx_locked: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_go && is_id_byte(idx) && !tx_open) |=>
      (tx_mem[$past(idx[1:0])] == $past(tx_mem[idx[1:0]])))
    else $error("locked transmit buffer was written"); // R10
  a_rx_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_store && !rx_full) |=> rx_full)
    else $error("receive-full flag lost on store"); // R11
  a_tx_empty_done: assert property (@(posedge clk) disable iff (!rst_n)
    tx_done |=> tx_empty)
    else $error("empty flag not set after arbitration field"); // R1

endmodule
`default_nettype wire

// File: src/can_idbuf_consts.svh
`ifndef CAN_IDBUF_CONSTS_SVH
`define CAN_IDBUF_CONSTS_SVH

// ==========================================================
// register indices (byte address = 4 * index)
`define IDX_ID_BYTE0 3'h0
`define IDX_ID_BYTE1 3'h1
`define IDX_ID_BYTE2 3'h2
`define IDX_ID_BYTE3 3'h3
`define IDX_TX_SEL 3'h4
`define IDX_STATUS 3'h5
`define IDX_TX_CTRL 3'h6

// ==========================================================
// field positions
`define SEL_TX_BIT 0
`define STAT_TXE_BIT 0
`define STAT_RXF_BIT 1
`define CTRL_REQ_BIT 0
`define CTRL_BUSY_BIT 1
`define B1_SRR_BIT 4
`define B1_IDE_BIT 3
`define B3_RTR_BIT 0

// ==========================================================
// arbitration field lengths in bits
`define EXT_ARB_BITS 6'h20
`define STD_ARB_BITS 6'h0d

// ==========================================================
// reset values
`define TXE_RESET 1'b1
`define RXF_RESET 1'b0
`define SEL_RESET 1'b0
`define RECESSIVE 1'b1

`endif

// File: src/can_idbuf_pkg.sv
package can_idbuf_pkg;

  // decoded identifier and frame-control bits
  typedef struct packed {
    logic [28:0] id;
    logic srr;
    logic ide;
    logic rtr;
  } id_frame_t;

  // the four identifier bytes, index 0 is the first byte
  typedef logic [3:0][7:0] id_bytes_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_SEND = 2'b01
  } ser_state_t;

endpackage

// File: src/id_byte_codec.sv
`timescale 1ns/10ps
`default_nettype none

module id_byte_codec (
  input wire can_idbuf_pkg::id_bytes_t bytes_in,
  input wire can_idbuf_pkg::id_frame_t frame_in,
  output can_idbuf_pkg::id_bytes_t bytes_out,
  output can_idbuf_pkg::id_frame_t frame_out
);
`include "can_idbuf_consts.svh"

  // ==========================================================
  // bytes to fields
  always_comb begin
    frame_out.id = {bytes_in[0], bytes_in[1][7:5], bytes_in[1][2:0],
                    bytes_in[2], bytes_in[3][7:1]}; // R3 R4 R9
    frame_out.srr = bytes_in[1][`B1_SRR_BIT];
    frame_out.ide = bytes_in[1][`B1_IDE_BIT]; // R7
    frame_out.rtr = bytes_in[3][`B3_RTR_BIT]; // R8
  end

  // ==========================================================
  // fields to bytes
  always_comb begin
    bytes_out[0] = frame_in.id[28:21]; // R9
    bytes_out[1] = {frame_in.id[20:18], frame_in.srr, frame_in.ide,
                    frame_in.id[17:15]}; // R3 R6 R7
    bytes_out[2] = frame_in.id[14:7]; // R4
    bytes_out[3] = {frame_in.id[6:0], frame_in.rtr}; // R4 R8
  end

endmodule
`default_nettype wire

// File: src/id_arb_shifter.sv
`timescale 1ns/10ps
`default_nettype none

module id_arb_shifter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire can_idbuf_pkg::id_frame_t frame,
  input wire logic bit_tick,
  input wire logic bus_bit,
  output logic tx_bit,
  output logic busy,
  output logic done,
  output logic lost
);
`include "can_idbuf_consts.svh"

  can_idbuf_pkg::ser_state_t state, next_state;
  logic [31:0] shift, next_shift, load_vec;
  logic [5:0] count, next_count;
  logic next_tx_bit, next_done, next_lost;

  assign busy = (state != can_idbuf_pkg::SER_IDLE);

  // ==========================================================
  // arbitration field, most significant identifier bit first
  always_comb begin
    if (frame.ide) begin
      load_vec = {frame.id[28:18], frame.srr, frame.ide,
                  frame.id[17:0], frame.rtr}; // R1
    end else begin
      load_vec = {frame.id[10:0], frame.rtr, frame.ide, 19'h0_0000};
    end
  end

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_count = count;
    next_tx_bit = tx_bit;
    next_done = 1'b0;
    next_lost = 1'b0;
    case (state)
      can_idbuf_pkg::SER_IDLE: begin
        next_tx_bit = `RECESSIVE;
        if (start) begin
          next_tx_bit = load_vec[31]; // R1
          next_shift = {load_vec[30:0], 1'b0};
          next_count = frame.ide ? `EXT_ARB_BITS : `STD_ARB_BITS;
          next_state = can_idbuf_pkg::SER_SEND;
        end
      end
      can_idbuf_pkg::SER_SEND: begin
        if (bit_tick) begin
          // recessive sent, dominant seen: a smaller id wins
          if (tx_bit && !bus_bit) begin
            next_lost = 1'b1; // R2
            next_tx_bit = `RECESSIVE;
            next_state = can_idbuf_pkg::SER_IDLE;
          end else if (count == 6'h01) begin
            next_done = 1'b1;
            next_tx_bit = `RECESSIVE;
            next_state = can_idbuf_pkg::SER_IDLE;
          end else begin
            next_tx_bit = shift[31];
            next_shift = {shift[30:0], 1'b0};
            next_count = count - 6'h01;
          end
        end
      end
      default: begin
        next_state = can_idbuf_pkg::SER_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= can_idbuf_pkg::SER_IDLE;
      shift <= 32'h0000_0000;
      count <= 6'h00;
      tx_bit <= `RECESSIVE;
      done <= 1'b0;
      lost <= 1'b0;
    end else begin
      state <= next_state;
      shift <= next_shift;
      count <= next_count;
      tx_bit <= next_tx_bit;
      done <= next_done;
      lost <= next_lost;
    end
  end

  // ==========================================================
  // checks
  a_msb_first: assert property (@(posedge clk) disable iff (!rst_n)
    (start && !busy && frame.ide) |=> (tx_bit == $past(frame.id[28])))
    else $error("first arbitration bit is not id bit 28"); // R1
  a_lost_cause: assert property (@(posedge clk) disable iff (!rst_n)
    lost |-> $past(bit_tick && tx_bit && !bus_bit && busy))
    else $error("arbitration lost without dominant overwrite"); // R2
  a_ext_length: assert property (@(posedge clk) disable iff (!rst_n)
    (start && !busy && frame.ide) |=> (count == 6'h20))
    else $error("extended arbitration length is not 32 bits"); // R1

endmodule
`default_nettype wire

// File: testbench/can_bus_node.sv
`timescale 1ns/10ps
`default_nettype none

module can_bus_node (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic can_tx,
  input wire logic arm,
  input wire logic [31:0] pattern,
  output logic bit_tick,
  output logic can_rx
);
  // ==========================================================
  // competing node, sixteen clocks per bit time
  logic [3:0] div;
  logic arm_q;
  logic [5:0] left;
  logic [31:0] sh;
  logic own;

  assign bit_tick = (div == 4'hf);
  assign own = (left != 6'h00) ? sh[31] : 1'b1;
  // wired-and bus; released means recessive, as with the pull-up
  assign can_rx = can_tx & own;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div <= 4'h0;
      arm_q <= 1'b0;
      left <= 6'h00;
      sh <= '1;
    end else begin
      div <= div + 4'h1;
      arm_q <= arm;
      if (arm && !arm_q) begin
        sh <= pattern;
        left <= 6'h20;
      end else if (bit_tick && left != 6'h00) begin
        sh <= {sh[30:0], 1'b1};
        // backs off on losing, as a real node does
        left <= (own && !can_rx) ? 6'h00 : left - 6'h01;
      end
    end
  end
endmodule

`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  // ==========================================================
  // wiring
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, rx_store, arm;
  logic bit_tick, can_rx, can_tx, tx_done, arb_lost;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, seen;
  can_idbuf_pkg::id_frame_t rx_frame, txf, rx_full_flag;
  int mismatches, tests_run, lost_cnt;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  can_extended_id_buffer_map u_can_extended_id_buffer_map (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_store(rx_store),
    .rx_frame(rx_frame), .bit_tick(bit_tick), .can_rx(can_rx),
    .can_tx(can_tx), .tx_done(tx_done), .arb_lost(arb_lost));

  can_bus_node u_can_bus_node (
    .clk(clk), .rst_n(rst_n), .can_tx(can_tx), .arm(arm),
    .pattern(32'h7fff_ffff), .bit_tick(bit_tick), .can_rx(can_rx));

  always @(posedge clk) begin
    if (arb_lost === 1'b1) lost_cnt++;
    if (bit_tick === 1'b1) seen <= {seen[30:0], can_tx};
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] pack(can_idbuf_pkg::id_frame_t f);
    return {f.id[28:18], f.srr, f.ide, f.id[17:0], f.rtr};
  endfunction

  function automatic logic [7:0] bsel(logic [31:0] p, int i);
    logic [31:0] q;
    q = p << (8 * i);
    return q[31:24];
  endfunction

  function automatic logic [31:0] layout(can_idbuf_pkg::id_frame_t f);
    return {f.id[28:18], f.srr, f.ide, f.id[17:0], f.rtr};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [2:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      mismatches++;
      final_report();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [2:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask

  task automatic rdbyte(input logic [2:0] idx, input logic [7:0] exp);
    rdchk(idx, {24'h00_0000, exp});
  endtask

  task automatic store(input can_idbuf_pkg::id_frame_t f);
    rx_store <= 1'b1;
    rx_frame <= f;
    @(posedge clk);
    rx_store <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tx_done !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      mismatches++;
      final_report();
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rdchk(3'h5, 32'h0000_0001);
    rdchk(3'h4, 32'h0000_0000);
    rdchk(3'h0, 32'h0000_0000);
    rdchk(3'h7, 32'h0000_0000);
  endtask

  task automatic t_txbuf;
    txf = '{id: 29'h1234_5678, srr: 1'b1, ide: 1'b1, rtr: 1'b0};
    bus(1'b1, 3'h4, 8'h01);
    for (int i = 0; i < 4; i++) bus(1'b1, 3'(i), bsel(pack(txf), i));
    for (int i = 0; i < 4; i++) rdbyte(3'(i), bsel(pack(txf), i));
    bus(1'b1, 3'h7, 8'hff);
    rdchk(3'h7, 32'h0000_0000);
  endtask

  task automatic t_rx;
    rx_full_flag = '{id: 29'h0abc_def1, srr: 1'b0, ide: 1'b1, rtr: 1'b1};
    store(rx_full_flag);
    bus(1'b1, 3'h4, 8'h00);
    for (int i = 0; i < 4; i++) rdbyte(3'(i), bsel(pack(rx_full_flag), i));
    bus(1'b1, 3'h0, 8'h55);
    rdbyte(3'h0, bsel(pack(rx_full_flag), 0));
    store('{id: 29'h0000_0001, srr: 1'b1, ide: 1'b0, rtr: 1'b0});
    rdbyte(3'h1, bsel(pack(rx_full_flag), 1));
    bus(1'b1, 3'h5, 8'h02);
    rdchk(3'h5, 32'h0000_0001);
    rdchk(3'h0, 32'h0000_0000);
  endtask

  // competitor sends a dominant first bit, then stays recessive
  task automatic t_tx_ext;
    bus(1'b1, 3'h4, 8'h01);
    do @(posedge clk); while (bit_tick !== 1'b1);
    arm <= 1'b1;
    bus(1'b1, 3'h6, 8'h01);
    rdchk(3'h0, 32'h0000_0000);
    rdchk(3'h6, 32'h0000_0002);
    wait_done();
    chk(seen, layout(txf));
    chk(lost_cnt, 32'h0000_0001);
    rdchk(3'h5, 32'h0000_0001);
  endtask

  task automatic t_tx_std;
    arm <= 1'b0;
    txf.ide = 1'b0;
    txf.rtr = 1'b1;
    for (int i = 0; i < 4; i++) bus(1'b1, 3'(i), bsel(pack(txf), i));
    bus(1'b1, 3'h6, 8'h01);
    wait_done();
    chk({30'h0000_0000, seen[1:0]}, 32'h0000_0002);
    chk(lost_cnt, 32'h0000_0001);
  endtask

  // ==========================================================
  // run control
  task automatic final_report;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #(4 * 20000);
    mismatches++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    rx_store = 1'b0;
    rx_frame = '0;
    arm = 1'b0;
    seen = 32'h0000_0000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_txbuf();
    t_rx();
    t_tx_ext();
    t_tx_std();
    final_report();
  end
endmodule

`default_nettype wire
